//--- pkg/mpi_pkg.sv
// shared constants and carrier types for the eight-port phy interface
package mpi_pkg;
  localparam int NPORT = 8;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  // last unit index of a byte: two nibbles or eight serial bits
  localparam logic [2:0] MII_LAST = 3'h1;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic RDY_RST = 1'b1;

  // one byte offered for transmit, last marks the end of the frame
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic last;
  } mpi_txreq_t;

  // one byte delivered from receive, last marks the end of the frame
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic last;
  } mpi_rxword_t;

  typedef logic [NIB_W-1:0] mpi_nib_t;
endpackage

//--- core/mpi_sync.sv
// two-flop level synchroniser, also used as a reset release synchroniser
`timescale 1ns/1ps
`default_nettype none
module mpi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

//--- core/mpi_ports.sv
// eight-port mii / 10 mbps serial transmit and receive paths to the phy
// What this block does
// - mii transmit drives one nibble per transmit edge
// - serial transmit uses bit zero, one bit/edge
// - serial transmit enable high preamble through last bit
// - mii transmit enable high first through last nibble
// - receive data and valid sampled on rising edge
// - mii receive captures one nibble per edge
// - serial receive ignores bits 3..1, takes bit zero
// - mii receive data counts only while valid high
`timescale 1ns/1ps
`default_nettype none
module mpi_ports
  import mpi_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [NPORT-1:0] serialMode,
  input wire mpi_txreq_t [NPORT-1:0] txReq,
  input wire logic [NPORT-1:0] txValid,
  output logic [NPORT-1:0] txReady,
  output mpi_rxword_t [NPORT-1:0] rxWord,
  output logic [NPORT-1:0] rxValid,
  input wire logic [NPORT-1:0] txClk,
  output mpi_nib_t [NPORT-1:0] txD,
  output logic [NPORT-1:0] txEn,
  input wire logic [NPORT-1:0] rxClk,
  input wire mpi_nib_t [NPORT-1:0] rxD,
  input wire logic [NPORT-1:0] rxDv
);
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    // ---------------- core side of transmit ----------------
    logic txRdy_r, txRdy_nxt, txReq_r, txReq_nxt, txAckSeen;
    mpi_txreq_t txHold_r, txHold_nxt;
    // ---------------- transmit clock domain ----------------
    logic txRstN, txSer, txReqSeen;
    logic [7:0] txSh_r, txSh_nxt;
    logic [2:0] txCnt_r, txCnt_nxt;
    logic txAct_r, txAct_nxt, txLast_r, txLast_nxt;
    logic txFrmSer_r, txFrmSer_nxt, txFull_r, txFull_nxt;
    logic txAck_r, txAck_nxt, txEn_r, txEn_nxt;
    mpi_nib_t txD_r, txD_nxt;
    mpi_txreq_t txBuf_r, txBuf_nxt;
    // ---------------- receive clock domain ----------------
    logic rxRstN, rxSer, rxDvS_r, rxDvS_nxt, rxHave_r, rxHave_nxt;
    logic rxW_r, rxW_nxt, rxDone, rxBit0;
    mpi_nib_t rxDS_r, rxDS_nxt;
    logic [7:0] rxSh_r, rxSh_nxt, rxPend_r, rxPend_nxt;
    logic [2:0] rxCnt_r, rxCnt_nxt;
    mpi_rxword_t rxSlot_r [2];
    mpi_rxword_t rxSlot_nxt [2];
    // ---------------- core side of receive ----------------
    logic rxWSeen, rdPar_r, rdPar_nxt, rxVal_r, rxVal_nxt;
    mpi_rxword_t rxOut_r, rxOut_nxt;

    // each link domain gets its own reset release
    mpi_sync #(.W(1)) u_txRst (.clk(txClk[p]), .rstN(nrst), .d(1'b1), .q(txRstN));
    mpi_sync #(.W(1)) u_rxRst (.clk(rxClk[p]), .rstN(nrst), .d(1'b1), .q(rxRstN));
    mpi_sync #(.W(1)) u_txSer (.clk(txClk[p]), .rstN(txRstN), .d(serialMode[p]), .q(txSer));
    mpi_sync #(.W(1)) u_rxSer (.clk(rxClk[p]), .rstN(rxRstN), .d(serialMode[p]), .q(rxSer));
    mpi_sync #(.W(1)) u_txReq (.clk(txClk[p]), .rstN(txRstN), .d(txReq_r), .q(txReqSeen));
    mpi_sync #(.W(1)) u_txAck (.clk(clock), .rstN(nrst), .d(txAck_r), .q(txAckSeen));
    mpi_sync #(.W(1)) u_rxW (.clk(clock), .rstN(nrst), .d(rxW_r), .q(rxWSeen));

    // core offer: hold the byte stable until the link domain acknowledges
    always_comb begin
      txRdy_nxt = txRdy_r;
      txReq_nxt = txReq_r;
      txHold_nxt = txHold_r;
      if (txRdy_r && txValid[p]) begin
        txHold_nxt = txReq[p];
        txReq_nxt = ~txReq_r;
        txRdy_nxt = 1'b0;
      end else if (!txRdy_r && txAckSeen == txReq_r) begin
        txRdy_nxt = 1'b1;
      end
    end

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        txRdy_r <= RDY_RST;
        txReq_r <= 1'b0;
        txHold_r <= '0;
      end else begin
        txRdy_r <= txRdy_nxt;
        txReq_r <= txReq_nxt;
        txHold_r <= txHold_nxt;
      end
    end

    // transmit shifter; the line format is frozen at the first byte of a frame
    always_comb begin
      txSh_nxt = txSh_r;
      txCnt_nxt = txCnt_r;
      txAct_nxt = txAct_r;
      txLast_nxt = txLast_r;
      txFrmSer_nxt = txFrmSer_r;
      txFull_nxt = txFull_r;
      txAck_nxt = txAck_r;
      txEn_nxt = txEn_r;
      txD_nxt = txD_r;
      txBuf_nxt = txBuf_r;
      if (!txAct_r || txCnt_r == CNT_RST) begin
        // chain the next byte without a gap; a finished frame forces one idle edge
        if (txFull_r && !(txAct_r && txLast_r)) begin
          txFrmSer_nxt = txAct_r ? txFrmSer_r : txSer;
          txAct_nxt = 1'b1;
          txEn_nxt = 1'b1;
          txLast_nxt = txBuf_r.last;
          txFull_nxt = 1'b0;
          if (txFrmSer_nxt) begin
            txD_nxt = {3'h0, txBuf_r.data[0]};
            txSh_nxt = txBuf_r.data >> 1;
            txCnt_nxt = SER_LAST;
          end else begin
            txD_nxt = txBuf_r.data[3:0];
            txSh_nxt = txBuf_r.data >> 4;
            txCnt_nxt = MII_LAST;
          end
        end else begin
          // end of frame, or underrun: enable drops, data parks at zero
          txAct_nxt = 1'b0;
          txEn_nxt = 1'b0;
          txD_nxt = NIB_RST;
        end
      end else begin
        txCnt_nxt = txCnt_r - 3'h1;
        if (txFrmSer_r) begin
          txD_nxt = {3'h0, txSh_r[0]};
          txSh_nxt = txSh_r >> 1;
        end else begin
          txD_nxt = txSh_r[3:0];
          txSh_nxt = txSh_r >> 4;
        end
      end
      // take the held byte only once the request toggle has settled here
      if (!txFull_r && txReqSeen != txAck_r) begin
        txBuf_nxt = txHold_r;
        txFull_nxt = 1'b1;
        txAck_nxt = ~txAck_r;
      end
    end

    // launched on the rising transmit edge of this port only
    always_ff @(posedge txClk[p] or negedge txRstN) begin
      if (!txRstN) begin
        txSh_r <= BYTE_RST;
        txCnt_r <= CNT_RST;
        txAct_r <= 1'b0;
        txLast_r <= 1'b0;
        txFrmSer_r <= 1'b0;
        txFull_r <= 1'b0;
        txAck_r <= 1'b0;
        txEn_r <= 1'b0;
        txD_r <= NIB_RST;
        txBuf_r <= '0;
      end else begin
        txSh_r <= txSh_nxt;
        txCnt_r <= txCnt_nxt;
        txAct_r <= txAct_nxt;
        txLast_r <= txLast_nxt;
        txFrmSer_r <= txFrmSer_nxt;
        txFull_r <= txFull_nxt;
        txAck_r <= txAck_nxt;
        txEn_r <= txEn_nxt;
        txD_r <= txD_nxt;
        txBuf_r <= txBuf_nxt;
      end
    end

    assign txD[p] = txD_r;
    assign txEn[p] = txEn_r;

    // receive assembly, lsb first; one byte is held back to learn its last flag
    always_comb begin
      rxDS_nxt = rxD[p];
      rxDvS_nxt = rxDv[p];
      rxSh_nxt = rxSh_r;
      rxCnt_nxt = rxCnt_r;
      rxPend_nxt = rxPend_r;
      rxHave_nxt = rxHave_r;
      rxW_nxt = rxW_r;
      rxSlot_nxt = rxSlot_r;
      rxDone = rxSer ? (rxCnt_r == SER_LAST) : (rxCnt_r == MII_LAST);
      if (rxDvS_r) begin
        if (rxSer) begin
          rxSh_nxt = {rxDS_r[0], rxSh_r[7:1]};
        end else begin
          rxSh_nxt = {rxDS_r, rxSh_r[7:4]};
        end
        rxCnt_nxt = rxDone ? CNT_RST : rxCnt_r + 3'h1;
        if (rxDone) begin
          if (rxHave_r) begin
            rxSlot_nxt[rxW_r] = '{data: rxPend_r, last: 1'b0};
            rxW_nxt = ~rxW_r;
          end
          rxPend_nxt = rxSh_nxt;
          rxHave_nxt = 1'b1;
        end
      end else begin
        // valid low: nothing shifts, a partial byte is dropped
        rxCnt_nxt = CNT_RST;
        if (rxHave_r) begin
          rxSlot_nxt[rxW_r] = '{data: rxPend_r, last: 1'b1};
          rxW_nxt = ~rxW_r;
        end
        rxHave_nxt = 1'b0;
      end
    end

    always_ff @(posedge rxClk[p] or negedge rxRstN) begin
      if (!rxRstN) begin
        rxDS_r <= NIB_RST;
        rxDvS_r <= 1'b0;
        rxSh_r <= BYTE_RST;
        rxCnt_r <= CNT_RST;
        rxPend_r <= BYTE_RST;
        rxHave_r <= 1'b0;
        rxW_r <= 1'b0;
        rxSlot_r <= '{default: '0};
      end else begin
        rxDS_r <= rxDS_nxt;
        rxDvS_r <= rxDvS_nxt;
        rxSh_r <= rxSh_nxt;
        rxCnt_r <= rxCnt_nxt;
        rxPend_r <= rxPend_nxt;
        rxHave_r <= rxHave_nxt;
        rxW_r <= rxW_nxt;
        rxSlot_r <= rxSlot_nxt;
      end
    end

    // two slots so a word stays stable for at least one link byte and one edge while core reads it
    always_comb begin
      rxVal_nxt = 1'b0;
      rxOut_nxt = rxOut_r;
      rdPar_nxt = rdPar_r;
      if (rxWSeen != rdPar_r) begin
        rxOut_nxt = rxSlot_r[rdPar_r];
        rxVal_nxt = 1'b1;
        rdPar_nxt = ~rdPar_r;
      end
    end

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        rxVal_r <= 1'b0;
        rxOut_r <= '0;
        rdPar_r <= 1'b0;
      end else begin
        rxVal_r <= rxVal_nxt;
        rxOut_r <= rxOut_nxt;
        rdPar_r <= rdPar_nxt;
      end
    end

    assign txReady[p] = txRdy_r;
    assign rxWord[p] = rxOut_r;
    assign rxValid[p] = rxVal_r;
    assign rxBit0 = rxDS_r[0];

    a_tx_mii_nibble: assert property (@(posedge txClk[p]) disable iff (!txRstN)
      (txAct_r && txCnt_r != 3'h0 && !txFrmSer_r) |=> ({4'h0, txD_r} == ($past(txSh_r) & 8'h0f)))
      else $error("mii nibble not taken from shifter");
    a_tx_serial_bit: assert property (@(posedge txClk[p]) disable iff (!txRstN)
      (txAct_r && txCnt_r != 3'h0 && txFrmSer_r) |=> ({4'h0, txD_r} == ($past(txSh_r) & 8'h01)))
      else $error("serial bit not on bit zero");
    a_tx_serial_en: assert property (@(posedge txClk[p]) disable iff (!txRstN)
      ($rose(txEn_r) && txFrmSer_r) |-> txEn_r [*8])
      else $error("serial enable shorter than one byte");
    a_tx_mii_en: assert property (@(posedge txClk[p]) disable iff (!txRstN)
      ($rose(txEn_r) && !txFrmSer_r) |-> txEn_r [*2])
      else $error("mii enable shorter than one byte");
    a_tx_en_chain: assert property (@(posedge txClk[p]) disable iff (!txRstN)
      (txEn_r && !txLast_r && txCnt_r == 3'h0 && txFull_r) |=> txEn_r)
      else $error("enable dropped inside frame");
    a_rx_mii_nib: assert property (@(posedge rxClk[p]) disable iff (!rxRstN)
      (rxDvS_r && !rxSer) |=> ((rxSh_r & 8'hf0) == {$past(rxDS_r), 4'h0}))
      else $error("mii nibble not captured");
    a_rx_serial_bit: assert property (@(posedge rxClk[p]) disable iff (!rxRstN)
      (rxDvS_r && rxSer) |=> (rxSh_r[7] == $past(rxBit0)))
      else $error("serial bit not captured from bit zero");
    a_rx_valid_gate: assert property (@(posedge rxClk[p]) disable iff (!rxRstN)
      !rxDvS_r |=> ($stable(rxSh_r) && rxCnt_r == 3'h0))
      else $error("receive data taken while valid low");
    // the last word of a frame follows its neighbour by one link edge, so two pulses may touch; never three
    a_rx_word_pulse: assert property (@(posedge clock) disable iff (!nrst)
      rxVal_r [*2] |=> !rxVal_r)
      else $error("more receive pulses in a row than slots");
  end
endmodule
`default_nettype wire

//--- testbench/mpi_phy_model.sv
// phy-side model: link clocks, transmit capture and receive frame driver
`timescale 1ns/1ps
`default_nettype none
module mpi_phy_model
  import mpi_pkg::*;
(
  input wire logic [NPORT-1:0] serialMode,
  output logic [NPORT-1:0] txClk,
  output logic [NPORT-1:0] rxClk,
  input wire mpi_nib_t [NPORT-1:0] txD,
  input wire logic [NPORT-1:0] txEn,
  output mpi_nib_t [NPORT-1:0] rxD,
  output logic [NPORT-1:0] rxDv
);
  logic [7:0] txBytes [NPORT][$];
  int frames [NPORT];
  int upperBad [NPORT];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [7:0] sh;
    int n = 0;
    logic prevEn = 1'b0;
    // free-running 6 ns clocks, each started at its own offset against the 5 ns core clock
    initial begin
      txClk[p] = 1'b0;
      #(0.7 + 0.4 * p);
      forever #3 txClk[p] = ~txClk[p];
    end
    initial begin
      rxClk[p] = 1'b0;
      rxDv[p] = 1'b0;
      rxD[p] = 4'h0;
      #(1.3 + 0.3 * p);
      forever #3 rxClk[p] = ~rxClk[p];
    end
    // idle data keeps toggling so stale values never look valid; on the rising edge so it never races the frame driver
    always @(posedge rxClk[p]) if (rxDv[p] === 1'b0) rxD[p] <= ~rxD[p];
    // rebuild bytes from the line, a new frame on each rise of enable
    always @(posedge txClk[p]) begin
      if (txEn[p] === 1'b1) begin
        if (!prevEn) begin
          frames[p]++;
          n = 0;
        end
        if (serialMode[p]) begin
          if (txD[p][3:1] !== 3'h0) upperBad[p]++;
          sh = {txD[p][0], sh[7:1]};
        end else begin
          sh = {txD[p], sh[7:4]};
        end
        n++;
        if (n == (serialMode[p] ? 8 : 2)) begin
          txBytes[p].push_back(sh);
          n = 0;
        end
      end
      prevEn = txEn[p];
    end
  end

  // drives a frame low unit first; serial puts junk on the unused upper lines
  task automatic rx_send(input int p, input logic [7:0] b[$], input bit ser);
    foreach (b[i]) begin
      for (int k = 0; k < (ser ? 8 : 2); k++) begin
        @(negedge rxClk[p]);
        rxDv[p] = 1'b1;
        rxD[p] = ser ? {~b[i][k], 2'h3, b[i][k]} : b[i][4*k+:4];
      end
    end
    @(negedge rxClk[p]);
    rxDv[p] = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the eight-port phy interface
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mpi_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [NPORT-1:0] serialMode = 8'h28;
  mpi_txreq_t [NPORT-1:0] txReq = '0;
  logic [NPORT-1:0] txValid = '0;
  logic [NPORT-1:0] txReady, rxValid, txClk, txEn, rxClk, rxDv;
  mpi_rxword_t [NPORT-1:0] rxWord;
  mpi_nib_t [NPORT-1:0] txD, rxD;
  logic [11:0] rxq [$];
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  always #2.5 clock = ~clock;

  mpi_ports dut (.clock(clock), .nrst(nrst), .serialMode(serialMode), .txReq(txReq), .txValid(txValid),
    .txReady(txReady), .rxWord(rxWord), .rxValid(rxValid), .txClk(txClk), .txD(txD), .txEn(txEn),
    .rxClk(rxClk), .rxD(rxD), .rxDv(rxDv));
  mpi_phy_model phy (.serialMode(serialMode), .txClk(txClk), .rxClk(rxClk), .txD(txD), .txEn(txEn),
    .rxD(rxD), .rxDv(rxDv));

  // received bytes tagged with their port
  always @(negedge clock) for (int p = 0; p < NPORT; p++) if (rxValid[p] === 1'b1) rxq.push_back({p[2:0], rxWord[p]});

  // a hang ends the run through the same report
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // valid held until a ready edge takes the byte, then the next one follows
  task automatic tx_frame(input int p, input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clock);
      txReq[p].data = b[i];
      txReq[p].last = (i == b.size() - 1);
      txValid[p] = 1'b1;
      for (int k = 0; k < 200 && txReady[p] !== 1'b1; k++) @(negedge clock);
    end
    @(negedge clock);
    txValid[p] = 1'b0;
  endtask

  task automatic wait_tx(input int p, input int n);
    for (int k = 0; k < 2000 && (phy.txBytes[p].size() < n || txEn[p] !== 1'b0); k++) @(negedge clock);
  endtask

  task automatic wait_rx(input int n);
    for (int k = 0; k < 2000 && rxq.size() < n; k++) @(negedge clock);
  endtask

  // outputs sit idle while reset is held
  task automatic t_reset();
    check(txReady, 32'hff, "ready in reset");
    check(txEn, 32'h0, "enable in reset");
    check(txD, 32'h0, "tx data in reset");
    check(rxValid, 32'h0, "rx valid in reset");
  endtask

  task automatic t_tx_mii();
    tx_frame(0, '{8'ha5});
    wait_tx(0, 1);
    check(phy.txBytes[0][0], 8'ha5, "mii tx byte");
    check(txReady[0], 1'b1, "ready back after frame");
    check(phy.frames[0], 1, "mii tx frames");
  endtask

  task automatic t_tx_ser();
    logic [7:0] exp [$];
    exp = '{8'h55, 8'h55, 8'hd5, 8'h3c};
    tx_frame(3, exp);
    wait_tx(3, 4);
    foreach (exp[i]) check(phy.txBytes[3][i], exp[i], "serial tx byte");
    check(phy.upperBad[3], 0, "serial upper lines");
    check(phy.frames[3], 1, "serial tx frames");
    check(phy.txBytes[0].size(), 1, "other port untouched");
  endtask

  task automatic t_rx_mii();
    phy.rx_send(1, '{8'h21, 8'h43}, 1'b0);
    wait_rx(2);
    check(rxq[0], {3'h1, 8'h21, 1'b0}, "mii rx first");
    check(rxq[1], {3'h1, 8'h43, 1'b1}, "mii rx last");
    rxq.delete();
  endtask

  task automatic t_rx_ser();
    phy.rx_send(5, '{8'hc6}, 1'b1);
    wait_rx(1);
    check(rxq[0], {3'h5, 8'hc6, 1'b1}, "serial rx byte");
    // give a stray extra word time to show up before counting
    repeat (60) @(negedge clock);
    check(rxq.size(), 1, "serial rx count");
  endtask

  task automatic final_report();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    t_reset();
    nrst = 1'b1;
    repeat (20) @(negedge clock);
    t_tx_mii();
    // transmit and receive of different ports run at once
    fork
      t_tx_ser();
      t_rx_mii();
    join
    t_rx_ser();
    final_report();
  end
endmodule
`default_nettype wire
